// file: logic/pdld_pkg.sv
package pdld_pkg;
  // Divider widths and limits
  localparam int REF_DIV_W = 12;
  localparam int FB_DIV_W = 18;
  localparam int PRE_DIV_W = 4;
  localparam int CH_DIV_W = 11;
  localparam int CNT_W = 14;
  localparam int DIV_W = 18;
  localparam int NUM_CH = 6;
  localparam logic [REF_DIV_W-1:0] REF_DIV_MIN = 12'h001;
  localparam logic [PRE_DIV_W-1:0] PRE_DIV_MIN = 4'h2;
  localparam logic [PRE_DIV_W-1:0] PRE_DIV_MAX = 4'h8;
  localparam logic [FB_DIV_W-1:0] FB_DIV_MIN = 18'h0_0001;
  localparam logic [CH_DIV_W-1:0] CH_DIV_MIN = 11'h001;
  localparam logic [CH_DIV_W-1:0] CH_DIV_MAX = 11'h415;
  // Lock window
  localparam int WIN_PS = 3700;
  localparam int CLK_PS = 10000;
  localparam int WIN_CYC_RAW = WIN_PS / CLK_PS;
  localparam int WIN_CYC = (WIN_CYC_RAW < 1) ? 1 : WIN_CYC_RAW;
  localparam logic [3:0] WIN_CYC_V = 4'(WIN_CYC);
  // Register map
  localparam logic [3:0] A_REF = 4'h0;
  localparam logic [3:0] A_FB = 4'h1;
  localparam logic [3:0] A_LOCKCNT = 4'h2;
  localparam logic [3:0] A_STAT = 4'h3;
  localparam logic [3:0] A_IRQ = 4'h4;
  localparam logic [3:0] A_MASK = 4'h5;
  localparam logic [3:0] A_CH0 = 4'h8;
  // Reset values
  localparam logic [REF_DIV_W-1:0] REF_DIV_RST = 12'h001;
  localparam logic [PRE_DIV_W-1:0] PRE_DIV_RST = 4'h2;
  localparam logic [FB_DIV_W-1:0] FB_DIV_RST = 18'h0_0001;
  localparam logic [CNT_W-1:0] LOCKCNT_RST = 14'h0400;
  localparam logic [CH_DIV_W-1:0] CH_DIV_RST = 11'h002;
  // Field positions
  localparam int DBL_BIT = 12;
  localparam int PRE_LSB = 18;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_LOSS = 1;
  typedef enum logic [1:0] {
    PDLD_IDLE,
    PDLD_WAIT_FB,
    PDLD_WAIT_REF
  } pdld_phase_e;
endpackage

// file: logic/pdld_divider.sv
`timescale 1ns/100ps
`default_nettype none
module pdld_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Source edge and setting
  input wire logic edge_in,
  input wire logic [pdld_pkg::DIV_W-1:0] div_val,
  // Divided outputs
  output logic out_pulse,
  output logic out_level
);
  logic [pdld_pkg::DIV_W-1:0] cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;
  logic lvl_r, lvl_nxt;
  logic [pdld_pkg::DIV_W-1:0] half;

  // Level high for first floor(n/2) edges, toggles every edge when n is 1; odd ratios allowed
  always_comb begin
    half = div_val >> 1;
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    lvl_nxt = lvl_r;
    if (edge_in) begin
      if (cnt_r + 18'h0_0001 >= div_val) begin
        cnt_nxt = '0;
        pulse_nxt = 1'b1;
        lvl_nxt = (div_val > 18'h0_0001);
      end else begin
        cnt_nxt = cnt_r + 18'h0_0001;
        lvl_nxt = (cnt_r + 18'h0_0001) < half;
      end
      if (div_val == 18'h0_0001) begin
        lvl_nxt = ~lvl_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= '0;
      pulse_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign out_pulse = pulse_r;
  assign out_level = lvl_r;
endmodule
`default_nettype wire

// file: logic/pdld_top.sv
// Contract
// (R01) Reference path divides by programmable value 1 to 4095.
// (R02) Doubler gives factor 1 when off, 2 when on, before divider.
// (R03) Prescaler divides oscillator by 2 through 8 before feedback divider.
// (R04) Feedback divider takes any value 1 to 262143.
// (R05) Software sets equal reference and feedback comparison rates.
// (R06) Software keeps comparison rate at or below 155 MHz.
// (R07) Each channel outputs oscillator divided by its own value, up to 1045.
// (R08) Channel dividers allow odd and even ratios from 2 to 1045.
// (R09) Software prefers doubler on with divide 2 over off with divide 1.
// (R10) Lock count increments per comparison with edges inside 3.7 ns window; code accepts edges up to one 10 ns sys_clk cycle apart.
// (R11) Edge pair outside window clears lock count to zero at once.
// (R12) Lock declared only after threshold consecutive in-window comparisons.
// (R13) Lock threshold comes from software-programmable lock count field.
// (R14) Lock holds while count at threshold, drops when count cleared.
`timescale 1ns/100ps
`default_nettype none
module pdld_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Source edges, one cycle pulses
  input wire logic ref_edge,
  input wire logic ref_edge_late,
  input wire logic osc_edge,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Comparison and lock
  output logic pd_ref_pulse,
  output logic pd_fb_pulse,
  output logic lock_detect,
  output logic irq,
  // Channel clocks
  output logic [pdld_pkg::NUM_CH-1:0] ch_clk
);

  // Configuration
  logic [pdld_pkg::REF_DIV_W-1:0] ref_div_r, ref_div_nxt;
  logic ref_doubler_enable_r, ref_doubler_enable_nxt;
  logic [pdld_pkg::PRE_DIV_W-1:0] pre_div_r, pre_div_nxt;
  logic [pdld_pkg::FB_DIV_W-1:0] fb_div_r, fb_div_nxt;
  logic [pdld_pkg::CNT_W-1:0] lock_count_threshold_r, lock_count_threshold_nxt;
  logic [pdld_pkg::CH_DIV_W-1:0] ch_div_r [pdld_pkg::NUM_CH];
  logic [pdld_pkg::CH_DIV_W-1:0] ch_div_nxt [pdld_pkg::NUM_CH];
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  // Lock detector
  pdld_pkg::pdld_phase_e phase_r, phase_nxt;
  logic [3:0] win_r, win_nxt;
  logic [pdld_pkg::CNT_W-1:0] lock_cnt_r, lock_cnt_nxt;
  logic lock_r, lock_nxt;
  // Divider chain wiring
  logic ref_mult_edge;
  logic pre_pulse;
  logic ref_pd;
  logic fb_pd;
  logic [pdld_pkg::DIV_W-1:0] ref_div_ext;
  logic [pdld_pkg::DIV_W-1:0] pre_div_ext;
  logic in_window;
  logic out_window;
  logic lock_rise;
  logic lock_fall;
  // Channel levels
  logic [pdld_pkg::NUM_CH-1:0] ch_lvl;
  logic [pdld_pkg::NUM_CH-1:0] ch_clk_nxt;

  // Doubler: both reference edges when enabled
  assign ref_mult_edge = ref_edge | (ref_doubler_enable_r & ref_edge_late); // R02
  assign ref_div_ext = {6'h00, ref_div_r};
  assign pre_div_ext = {14'h0000, pre_div_r};

  pdld_divider u_ref_div ( // R01
    .sys_clk(sys_clk),
    .rst(rst),
    .edge_in(ref_mult_edge),
    .div_val(ref_div_ext),
    .out_pulse(ref_pd),
    .out_level()
  );

  pdld_divider u_pre_div ( // R03
    .sys_clk(sys_clk),
    .rst(rst),
    .edge_in(osc_edge),
    .div_val(pre_div_ext),
    .out_pulse(pre_pulse),
    .out_level()
  );

  pdld_divider u_fb_div ( // R04
    .sys_clk(sys_clk),
    .rst(rst),
    .edge_in(pre_pulse),
    .div_val(fb_div_r),
    .out_pulse(fb_pd),
    .out_level()
  );

  // Channel dividers, one per output
  genvar gi;
  generate
    for (gi = 0; gi < pdld_pkg::NUM_CH; gi++) begin : g_ch
      pdld_divider u_ch_div ( // R07
        .sys_clk(sys_clk),
        .rst(rst),
        .edge_in(osc_edge),
        .div_val({7'h00, ch_div_r[gi]}),
        .out_pulse(),
        .out_level(ch_lvl[gi])
      );
    end
  endgenerate

  // Channel clock registers
  always_comb begin
    ch_clk_nxt = ch_lvl;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ch_clk <= '0;
    end else begin
      ch_clk <= ch_clk_nxt;
    end
  end

  // Window check on edge pairs
  always_comb begin
    phase_nxt = phase_r;
    win_nxt = win_r;
    in_window = 1'b0;
    out_window = 1'b0;
    case (phase_r)
      pdld_pkg::PDLD_IDLE: begin
        if (ref_pd && fb_pd) begin
          in_window = 1'b1; // R10
        end else if (ref_pd) begin
          phase_nxt = pdld_pkg::PDLD_WAIT_FB;
          win_nxt = '0;
        end else if (fb_pd) begin
          phase_nxt = pdld_pkg::PDLD_WAIT_REF;
          win_nxt = '0;
        end
      end
      pdld_pkg::PDLD_WAIT_FB, pdld_pkg::PDLD_WAIT_REF: begin
        win_nxt = win_r + 4'h1;
        if ((phase_r == pdld_pkg::PDLD_WAIT_FB && fb_pd) ||
            (phase_r == pdld_pkg::PDLD_WAIT_REF && ref_pd)) begin
          phase_nxt = pdld_pkg::PDLD_IDLE;
          if (win_r + 4'h1 <= pdld_pkg::WIN_CYC_V) begin
            in_window = 1'b1; // R10
          end else begin
            out_window = 1'b1; // R11
          end
        end else if (win_r + 4'h1 > pdld_pkg::WIN_CYC_V) begin
          out_window = 1'b1; // R11
          phase_nxt = pdld_pkg::PDLD_IDLE;
        end
      end
      default: begin
        phase_nxt = pdld_pkg::PDLD_IDLE;
      end
    endcase
  end

  // Window state and comparison pulse registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_r <= pdld_pkg::PDLD_IDLE;
      win_r <= 4'h0;
      pd_ref_pulse <= 1'b0;
      pd_fb_pulse <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      win_r <= win_nxt;
      pd_ref_pulse <= ref_pd;
      pd_fb_pulse <= fb_pd;
    end
  end

  // Lock count and flag
  always_comb begin
    lock_cnt_nxt = lock_cnt_r;
    lock_nxt = lock_r;
    // Out-of-window pair clears at once
    if (out_window) begin
      lock_cnt_nxt = '0; // R11
      lock_nxt = 1'b0; // R14
    end else if (in_window) begin
      // Count saturates at all ones
      if (lock_cnt_r != '1) begin
        lock_cnt_nxt = lock_cnt_r + 14'h0001; // R10
      end
      if (lock_cnt_r + 14'h0001 >= lock_count_threshold_r) begin
        lock_nxt = 1'b1; // R12 R13
      end
    end
  end

  // Lock registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_cnt_r <= '0;
      lock_r <= 1'b0;
    end else begin
      lock_cnt_r <= lock_cnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign lock_rise = lock_nxt & ~lock_r;
  assign lock_fall = ~lock_nxt & lock_r;

  // Register writes, reads and interrupt status
  always_comb begin
    ref_div_nxt = ref_div_r;
    ref_doubler_enable_nxt = ref_doubler_enable_r;
    pre_div_nxt = pre_div_r;
    fb_div_nxt = fb_div_r;
    lock_count_threshold_nxt = lock_count_threshold_r;
    irq_mask_nxt = irq_mask_r;
    for (int i = 0; i < pdld_pkg::NUM_CH; i++) begin
      ch_div_nxt[i] = ch_div_r[i];
    end
    irq_stat_nxt = irq_stat_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        pdld_pkg::A_REF: begin
          if (reg_wdata[pdld_pkg::REF_DIV_W-1:0] >= pdld_pkg::REF_DIV_MIN) begin
            ref_div_nxt = reg_wdata[pdld_pkg::REF_DIV_W-1:0]; // R01
          end
          ref_doubler_enable_nxt = reg_wdata[pdld_pkg::DBL_BIT]; // R02
        end
        pdld_pkg::A_FB: begin
          if (reg_wdata[pdld_pkg::FB_DIV_W-1:0] >= pdld_pkg::FB_DIV_MIN) begin
            fb_div_nxt = reg_wdata[pdld_pkg::FB_DIV_W-1:0]; // R04
          end
          if (reg_wdata[pdld_pkg::PRE_LSB +: pdld_pkg::PRE_DIV_W] >= pdld_pkg::PRE_DIV_MIN &&
              reg_wdata[pdld_pkg::PRE_LSB +: pdld_pkg::PRE_DIV_W] <= pdld_pkg::PRE_DIV_MAX) begin
            pre_div_nxt = reg_wdata[pdld_pkg::PRE_LSB +: pdld_pkg::PRE_DIV_W]; // R03
          end
        end
        pdld_pkg::A_LOCKCNT: begin
          lock_count_threshold_nxt = reg_wdata[pdld_pkg::CNT_W-1:0]; // R13
        end
        pdld_pkg::A_MASK: begin
          irq_mask_nxt = reg_wdata[1:0];
        end
        default: begin
          if (reg_addr >= pdld_pkg::A_CH0 &&
              reg_addr < pdld_pkg::A_CH0 + 4'(pdld_pkg::NUM_CH) &&
              reg_wdata[pdld_pkg::CH_DIV_W-1:0] >= pdld_pkg::CH_DIV_MIN &&
              reg_wdata[pdld_pkg::CH_DIV_W-1:0] <= pdld_pkg::CH_DIV_MAX) begin
            ch_div_nxt[3'(reg_addr - pdld_pkg::A_CH0)] =
              reg_wdata[pdld_pkg::CH_DIV_W-1:0]; // R07 R08
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        pdld_pkg::A_REF: begin
          rdata_nxt = {19'h0_0000, ref_doubler_enable_r, ref_div_r};
        end
        pdld_pkg::A_FB: begin
          rdata_nxt = {10'h000, pre_div_r, fb_div_r};
        end
        pdld_pkg::A_LOCKCNT: begin
          rdata_nxt = {18'h0_0000, lock_count_threshold_r};
        end
        pdld_pkg::A_STAT: begin
          rdata_nxt = {17'h0_0000, lock_r, lock_cnt_r};
        end
        pdld_pkg::A_IRQ: begin
          rdata_nxt = {30'h0000_0000, irq_stat_r};
          irq_stat_nxt = 2'h0;
        end
        pdld_pkg::A_MASK: begin
          rdata_nxt = {30'h0000_0000, irq_mask_r};
        end
        default: begin
          if (reg_addr >= pdld_pkg::A_CH0 &&
              reg_addr < pdld_pkg::A_CH0 + 4'(pdld_pkg::NUM_CH)) begin
            rdata_nxt = {21'h00_0000, ch_div_r[3'(reg_addr - pdld_pkg::A_CH0)]};
          end
        end
      endcase
    end
    // Set wins over read clear
    if (lock_rise) begin
      irq_stat_nxt[pdld_pkg::IRQ_LOCK] = 1'b1;
    end
    if (lock_fall) begin
      irq_stat_nxt[pdld_pkg::IRQ_LOSS] = 1'b1;
    end
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  // Configuration and status registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_div_r <= pdld_pkg::REF_DIV_RST;
      ref_doubler_enable_r <= 1'b0;
      pre_div_r <= pdld_pkg::PRE_DIV_RST;
      fb_div_r <= pdld_pkg::FB_DIV_RST;
      lock_count_threshold_r <= pdld_pkg::LOCKCNT_RST;
      irq_mask_r <= 2'h0;
      irq_stat_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      for (int i = 0; i < pdld_pkg::NUM_CH; i++) begin
        ch_div_r[i] <= pdld_pkg::CH_DIV_RST;
      end
    end else begin
      ref_div_r <= ref_div_nxt;
      ref_doubler_enable_r <= ref_doubler_enable_nxt;
      pre_div_r <= pre_div_nxt;
      fb_div_r <= fb_div_nxt;
      lock_count_threshold_r <= lock_count_threshold_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      for (int i = 0; i < pdld_pkg::NUM_CH; i++) begin
        ch_div_r[i] <= ch_div_nxt[i];
      end
    end
  end

  // Outputs straight from registers
  assign reg_rdata = rdata_r;
  assign lock_detect = lock_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// file: testbench/pdld_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pdld_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Stimulus side
  input wire logic ref_edge,
  input wire logic ref_edge_late,
  input wire logic osc_edge,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Design outputs
  input wire logic [31:0] reg_rdata,
  input wire logic pd_ref_pulse,
  input wire logic pd_fb_pulse,
  input wire logic lock_detect,
  input wire logic irq,
  input wire logic [pdld_pkg::NUM_CH-1:0] ch_clk
);
  // Recent source edges and comparison pulses
  logic [3:0] ref_h;
  logic [3:0] osc_h;
  logic [2:0] pd_h;
  always_ff @(posedge sys_clk) begin
    ref_h <= {ref_h[2:0], ref_edge | ref_edge_late};
    osc_h <= {osc_h[2:0], osc_edge};
    pd_h <= {pd_h[1:0], pd_ref_pulse | pd_fb_pulse};
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_stat_rd;
    reg_rd && reg_addr == pdld_pkg::A_STAT;
  endsequence
  sequence s_pair_seen;
    pd_ref_pulse || pd_fb_pulse || (|pd_h);
  endsequence
  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_stat_lock_bit: assert property (s_stat_rd |=>
    reg_rdata[31:14] == {17'h0, $past(lock_detect)})
    else $error("status lock bit differs from lock output");
  a_ref_from_edge: assert property (pd_ref_pulse |-> |{ref_h, ref_edge})
    else $error("reference pulse without reference edge");
  a_fb_from_osc: assert property (pd_fb_pulse |-> |{osc_h, osc_edge})
    else $error("feedback pulse without oscillator edge");
  a_fb_spacing: assert property (pd_fb_pulse |=> !pd_fb_pulse)
    else $error("feedback pulses closer than prescale allows");
  a_ch_from_osc: assert property ($changed(ch_clk) |-> |{osc_h, osc_edge})
    else $error("channel clock moved without oscillator edge");
  a_lock_rise_pair: assert property ($rose(lock_detect) |-> s_pair_seen)
    else $error("lock rose without a comparison");
  a_lock_fall_pair: assert property ($fell(lock_detect) |-> s_pair_seen)
    else $error("lock fell without a comparison");
endmodule
bind pdld_top pdld_properties u_props (
  .sys_clk(sys_clk), .rst(rst), .ref_edge(ref_edge), .ref_edge_late(ref_edge_late),
  .osc_edge(osc_edge), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pd_ref_pulse(pd_ref_pulse),
  .pd_fb_pulse(pd_fb_pulse), .lock_detect(lock_detect), .irq(irq), .ch_clk(ch_clk)
);
`default_nettype wire

// file: testbench/pll_divider_lock_detect_test.sv
`timescale 1ns/100ps
`default_nettype none
module pll_divider_lock_detect_test;
  logic sys_clk, rst, ref_edge, ref_edge_late, osc_edge, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic pd_ref_pulse, pd_fb_pulse, lock_detect, irq;
  logic [pdld_pkg::NUM_CH-1:0] ch_clk, ch_q;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_ref = 0, n_fb = 0, n_ch0 = 0, n_ch1 = 0, n_chx = 0;
  pdld_top dut (
    .sys_clk(sys_clk), .rst(rst), .ref_edge(ref_edge), .ref_edge_late(ref_edge_late),
    .osc_edge(osc_edge), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pd_ref_pulse(pd_ref_pulse),
    .pd_fb_pulse(pd_fb_pulse), .lock_detect(lock_detect), .irq(irq), .ch_clk(ch_clk)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Pulse counters and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    ch_q <= ch_clk;
    n_ref <= n_ref + int'(pd_ref_pulse);
    n_fb <= n_fb + int'(pd_fb_pulse);
    n_ch0 <= n_ch0 + int'(ch_clk[0] && !ch_q[0]);
    n_ch1 <= n_ch1 + int'(ch_clk[1] && !ch_q[1]);
    n_chx <= n_chx + $countones(ch_clk[pdld_pkg::NUM_CH-1:2] & ~ch_q[pdld_pkg::NUM_CH-1:2]);
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  // Lock and interrupt levels a little after the last edge
  task automatic lk(input logic l, input logic i);
    repeat (2) @(posedge sys_clk);
    #1 chk({30'h0, lock_detect, irq}, {30'h0, l, i});
    @(posedge sys_clk);
  endtask
  // Each pair is two input edges, both paths divide by two
  task automatic pairs(input int k, input logic o);
    repeat (2 * k) begin
      ref_edge <= 1'b1;
      osc_edge <= o;
      @(posedge sys_clk);
      ref_edge <= 1'b0;
      osc_edge <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
  endtask
  task automatic drive(input int k, input logic d);
    for (int i = 0; i < k; i++) begin
      ref_edge <= (i % 2 == 0);
      ref_edge_late <= d && (i % 2 == 1);
      osc_edge <= 1'b1;
      @(posedge sys_clk);
    end
  endtask
  task automatic t_reset();
    rd(pdld_pkg::A_REF, 32'h1);
    rd(pdld_pkg::A_FB, 32'h8_0001);
    rd(pdld_pkg::A_LOCKCNT, 32'h400);
    rd(pdld_pkg::A_STAT, 32'h0);
    rd(pdld_pkg::A_CH0, 32'h2);
    $display("test reset done");
  endtask
  task automatic t_limits();
    wr(pdld_pkg::A_REF, 32'hFFF);
    wr(pdld_pkg::A_REF, 32'h0);
    rd(pdld_pkg::A_REF, 32'hFFF);
    wr(pdld_pkg::A_FB, 32'h23_FFFF);
    wr(pdld_pkg::A_FB, 32'h24_0000);
    rd(pdld_pkg::A_FB, 32'h23_FFFF);
    wr(pdld_pkg::A_FB, 32'h4_0005);
    rd(pdld_pkg::A_FB, 32'h20_0005);
    wr(pdld_pkg::A_CH0, 32'h415);
    wr(pdld_pkg::A_CH0, 32'h416);
    rd(pdld_pkg::A_CH0, 32'h415);
    wr(pdld_pkg::A_CH0 + 4'h5, 32'h0);
    rd(pdld_pkg::A_CH0 + 4'h5, 32'h2);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0);
    $display("test limits done");
  endtask
  task automatic t_lock();
    wr(pdld_pkg::A_REF, 32'h2);
    wr(pdld_pkg::A_FB, 32'h8_0001);
    wr(pdld_pkg::A_LOCKCNT, 32'h3);
    wr(pdld_pkg::A_MASK, 32'h3);
    pairs(2, 1'b1);
    lk(1'b0, 1'b0);
    pairs(1, 1'b1);
    lk(1'b1, 1'b1);
    rd(pdld_pkg::A_STAT, 32'h4003);
    rd(pdld_pkg::A_IRQ, 32'h1);
    lk(1'b1, 1'b0);
    pairs(1, 1'b0);
    lk(1'b0, 1'b1);
    rd(pdld_pkg::A_IRQ, 32'h2);
    rd(pdld_pkg::A_STAT, 32'h0);
    pairs(2, 1'b1);
    lk(1'b0, 1'b0);
    $display("test lock done");
  endtask
  task automatic t_rate(input logic [11:0] r, input logic d, input logic [3:0] p,
      input logic [17:0] n, input logic [10:0] c, input int m, input int er,
      input int ef, input int ec);
    int b0, b1, b2, b3, b4;
    wr(pdld_pkg::A_REF, {19'h0, d, r});
    wr(pdld_pkg::A_FB, {10'h0, p, n});
    wr(pdld_pkg::A_CH0, {21'h0, c});
    drive(2100, d);
    b0 = n_ref;
    b1 = n_fb;
    b2 = n_ch0;
    b3 = n_ch1;
    b4 = n_chx;
    drive(m, d);
    ref_edge <= 1'b0;
    ref_edge_late <= 1'b0;
    osc_edge <= 1'b0;
    chk(n_ref - b0, er);
    chk(n_fb - b1, ef);
    chk(n_ch0 - b2, ec);
    chk(n_ch1 - b3, m / 2);
    chk(n_chx - b4, (pdld_pkg::NUM_CH - 2) * m / 2);
    $display("test rate done");
  endtask
  initial begin
    rst = 1'b1;
    ref_edge = 1'b0;
    ref_edge_late = 1'b0;
    osc_edge = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_limits();
    t_lock();
    t_rate(12'h3, 1'b0, 4'h2, 18'h3, 11'h5, 60, 10, 10, 12);
    t_rate(12'h2, 1'b1, 4'h2, 18'h1, 11'h7, 168, 84, 84, 24);
    t_rate(12'h5, 1'b0, 4'h2, 18'h5, 11'h415, 2090, 209, 209, 2);
    stop_test();
  end
endmodule
`default_nettype wire
